// ---- hw/scdc_pkg.sv ----
package scdc_pkg;
   // ====================================================================
   // register map
   // ====================================================================
   // printed offsets are multiples of four? 0xff58 yes, 0xfff3 and 0xfffb
   // are not, so every printed offset is an index and byte address = 4*idx
   localparam logic [15:0] SCDC_IDX_LOW_SPEED_OSC_MODE = 16'hFF58;
   localparam logic [15:0] SCDC_IDX_PERIPHERAL_CLOCK_DIVIDER = 16'hFFF3;
   localparam logic [15:0] SCDC_IDX_CPU_CLOCK_DIVIDER = 16'hFFFB;
   // own status register: source and oscillator states
   localparam logic [15:0] SCDC_IDX_CLOCK_STATUS = 16'hFF60;
   localparam int SCDC_ADDR_W = 18;

   // ====================================================================
   // reset values and field positions
   // ====================================================================
   localparam logic [7:0] SCDC_RST_CPU_DIV = 8'h02;
   localparam logic [7:0] SCDC_RST_PERIPH_DIV = 8'h02;
   localparam logic [7:0] SCDC_RST_LSO_MODE = 8'h00;
   localparam logic [7:0] SCDC_MASK_CPU_DIV = 8'h02;     // only cpu_div_sel
   localparam logic [7:0] SCDC_MASK_PERIPH_DIV = 8'h03;  // periph_div_hi/lo
   localparam logic [7:0] SCDC_MASK_LSO_MODE = 8'h01;    // only stop bit
   localparam int SCDC_BIT_CPU_DIV_SEL = 1;
   localparam int SCDC_BIT_PERIPH_DIV_HI = 1;
   localparam int SCDC_BIT_PERIPH_DIV_LO = 0;
   localparam int SCDC_BIT_LSO_STOP = 0;
   // status bits
   localparam int SCDC_ST_EXT_SRC = 0;
   localparam int SCDC_ST_LSO_RUN = 1;
   localparam int SCDC_ST_SYS_RUN = 2;
   localparam int SCDC_ST_PROHIBITED = 3;

   // ====================================================================
   // divider encodings and timing
   // ====================================================================
   localparam logic [4:0] SCDC_LOG2_MAX_DIV = 5'd4;  // largest ratio 2^4
   localparam int SCDC_MIN_INSTR_CPU_CLKS = 2;        // shortest instruction
   localparam int SCDC_INT_OSC_KHZ = 8000;
   localparam int SCDC_EXT_MIN_KHZ = 2000;
   localparam int SCDC_EXT_MAX_KHZ = 10000;
   localparam int SCDC_LSO_KHZ = 240;
   localparam logic [1:0] SCDC_RESP_OKAY = 2'b00;
   localparam logic [1:0] SCDC_RESP_SLVERR = 2'b10;
endpackage : scdc_pkg

// ---- hw/scdc_clock_control.sv ----
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none

// Function
// - cpu and peripheral dividers reset to 02H
// - cpu clock ratio from three select bits
// - peripheral 01H gives /2, 02H gives /4
// - shortest instruction is two cpu clocks
// - bit and byte writes both supported
// - low-speed mode register resets to 00H
// - bit 0 is stop control, 0 runs
// - stop bit 1 halts oscillator when permitted
// - forbidden stopping ignores writes, fixes watchdog source
// - stop instruction halts the selected source
// - configuration picks internal or external source
// - internal source frees external pin for port
// - peripheral ratio 1, 2, 4; code 11 prohibited
module scdc_clock_control
   import scdc_pkg::*;
#(
   parameter int DATA_W = 32
) (
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite slave
   input wire logic [SCDC_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [DATA_W-1:0] s_axi_wdata,
   input wire logic [DATA_W/8-1:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [SCDC_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [DATA_W-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // one-time configuration and core signals
   input wire logic cfg_ext_clk_sel,     // 1: external clock pin is source
   input wire logic cfg_lso_sw_stop_ok,  // 1: software may stop low-speed osc
   input wire logic stop_mode,           // level while stop instruction holds
   // clock enables derived from sys_clk (aclk stands for sys_clk)
   output logic cpu_clk_en,
   output logic periph_clk_en,
   output logic [5:0] min_instr_sys_clks, // shortest instruction in sys_clk
   // oscillator and pin controls
   output logic int_osc_enable,
   output logic ext_clk_gate_open,
   output logic external_clock_pin_is_port,
   output logic lso_enable,
   output logic wdt_src_fixed_lso
);

   // ====================================================================
   // checks
   // ====================================================================
   // each register is one 32-bit word; the lane merge serves no other width,
   // so a wider or narrower bus is refused at elaboration
   if (DATA_W != 32) begin : g_bad_data_w
      $error("scdc_clock_control: DATA_W must be 32");
   end

   // ====================================================================
   // functions
   // ====================================================================
   // merge one byte lane under strobe, keep only implemented bits
   // a single-bit software write reaches us as a whole byte after the core's
   // read-modify-write, so this one path serves both access widths
   function automatic logic [7:0] merge_byte(input logic [7:0] old_v,
                                             input logic [7:0] new_v,
                                             input logic strb,
                                             input logic [7:0] mask);
      logic [7:0] r;
      r = strb ? new_v : old_v;
      merge_byte = r & mask;
   endfunction : merge_byte

   // register index taken from a byte address, word aligned
   // low two address bits are ignored, so byte offsets in a word alias
   function automatic logic [15:0] addr_idx(input logic [SCDC_ADDR_W-1:0] a);
      addr_idx = a[SCDC_ADDR_W-1:2];
   endfunction : addr_idx

   // cpu ratio as log2, 5'h1F marks a prohibited code
   // select bits are {periph_div_hi, periph_div_lo, cpu_div_sel}, so the
   // peripheral setting shapes the cpu ratio as well
   function automatic logic [4:0] cpu_log2(input logic [2:0] sel);
      unique case (sel)
         3'b000: cpu_log2 = 5'd0;
         3'b010: cpu_log2 = 5'd1;
         3'b001: cpu_log2 = 5'd2;
         3'b100: cpu_log2 = 5'd2;
         3'b011: cpu_log2 = 5'd3;
         3'b101: cpu_log2 = 5'd4;
         default: cpu_log2 = 5'h1F;
      endcase
   endfunction : cpu_log2

   // ====================================================================
   // registers
   // ====================================================================
   logic [7:0] cpu_clock_divider;         // only cpu_div_sel lives
   logic [7:0] peripheral_clock_divider;  // periph_div_hi/lo
   logic [7:0] low_speed_osc_mode;        // low_speed_osc_stop
   // write halves may arrive in either order; each is parked until both meet
   logic [SCDC_ADDR_W-1:0] wr_addr;       // captured write address
   logic aw_held;                         // write address taken, waiting data
   logic [DATA_W-1:0] wr_data;
   logic [DATA_W/8-1:0] wr_strb;
   logic w_held;                          // write data taken
   logic do_write;                        // both halves present
   logic wr_hit;

   // ====================================================================
   // axi write channel
   // ====================================================================
   // accept each half while it is not already held and no response waits
   // one write in flight at most: a new one waits until bresp is taken
   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready = !w_held && !s_axi_bvalid;
   assign do_write = aw_held && w_held;

   // address half
   // address is kept until the data half arrives too
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         wr_addr <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held <= 1'b1;
         wr_addr <= s_axi_awaddr;
      end else if (do_write) begin
         aw_held <= 1'b0;
      end
   end

   // data half
   // strobe is kept with the data; only lane 0 is ever looked at
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held <= 1'b0;
         wr_data <= '0;
         wr_strb <= '0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held <= 1'b1;
         wr_data <= s_axi_wdata;
         wr_strb <= s_axi_wstrb;
      end else if (do_write) begin
         w_held <= 1'b0;
      end
   end

   // unmapped or status write answers slverr
   // status is read-only, so a write to it is refused like a hole
   always_comb begin
      unique case (addr_idx(wr_addr))
         SCDC_IDX_CPU_CLOCK_DIVIDER,
         SCDC_IDX_PERIPHERAL_CLOCK_DIVIDER,
         SCDC_IDX_LOW_SPEED_OSC_MODE: wr_hit = 1'b1;
         default: wr_hit = 1'b0;
      endcase
   end

   // write response one cycle after both halves meet
   // do_write wins over bready, so a fresh response is never lost
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= SCDC_RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_hit ? SCDC_RESP_OKAY : SCDC_RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // ====================================================================
   // control registers
   // ====================================================================
   // byte lane 0 write; a bit write is a read-modify-write of this lane,
   // so whole-byte and single-bit software access land the same way
   // upper bits are masked on write, so they always read back as zero
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cpu_clock_divider <= SCDC_RST_CPU_DIV;
         peripheral_clock_divider <= SCDC_RST_PERIPH_DIV;
      end else if (do_write) begin
         if (addr_idx(wr_addr) == SCDC_IDX_CPU_CLOCK_DIVIDER) begin
            cpu_clock_divider <= merge_byte(cpu_clock_divider, wr_data[7:0],
                                            wr_strb[0], SCDC_MASK_CPU_DIV);
         end
         if (addr_idx(wr_addr) == SCDC_IDX_PERIPHERAL_CLOCK_DIVIDER) begin
            peripheral_clock_divider <= merge_byte(peripheral_clock_divider,
                                                   wr_data[7:0], wr_strb[0],
                                                   SCDC_MASK_PERIPH_DIV);
         end
      end
   end

   // low-speed oscillator mode; writes dropped while stopping forbidden
   // trade-off: a refused stop write still answers okay, since software
   // cannot see the setting and an error would only confuse its driver
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         low_speed_osc_mode <= SCDC_RST_LSO_MODE;
      end else if (do_write && cfg_lso_sw_stop_ok &&
                   addr_idx(wr_addr) == SCDC_IDX_LOW_SPEED_OSC_MODE) begin
         low_speed_osc_mode <= merge_byte(low_speed_osc_mode, wr_data[7:0],
                                          wr_strb[0], SCDC_MASK_LSO_MODE);
      end
   end

   // ====================================================================
   // axi read channel
   // ====================================================================
   logic [7:0] rd_byte;
   logic rd_hit;
   logic [7:0] status_byte;
   logic [4:0] cpu_l2;
   logic [1:0] periph_code;
   logic prohibited;

   // reads have no side effect, so the mux looks at araddr directly and
   // the registered answer carries it one cycle later
   assign s_axi_arready = !s_axi_rvalid;

   // read mux, upper bytes always zero
   always_comb begin
      rd_byte = 8'h00;
      rd_hit = 1'b1;
      unique case (addr_idx(s_axi_araddr))
         SCDC_IDX_CPU_CLOCK_DIVIDER: rd_byte = cpu_clock_divider;
         SCDC_IDX_PERIPHERAL_CLOCK_DIVIDER: rd_byte = peripheral_clock_divider;
         SCDC_IDX_LOW_SPEED_OSC_MODE: rd_byte = low_speed_osc_mode;
         SCDC_IDX_CLOCK_STATUS: rd_byte = status_byte;
         default: rd_hit = 1'b0;
      endcase
   end

   // read data registered, one cycle after address taken
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= SCDC_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= {{(DATA_W-8){1'b0}}, rd_byte};
         s_axi_rresp <= rd_hit ? SCDC_RESP_OKAY : SCDC_RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ====================================================================
   // source selection and oscillator control
   // ====================================================================
   // config picks internal 8 MHz or external 2-10 MHz pin clock
   // stop_mode only gates the source; every register keeps its contents
   // the pin returns to port use whenever the internal source runs
   assign int_osc_enable = !cfg_ext_clk_sel && !stop_mode;
   assign ext_clk_gate_open = cfg_ext_clk_sel && !stop_mode;
   assign external_clock_pin_is_port = !cfg_ext_clk_sel;
   // stop bit honoured only when software stopping allowed
   assign lso_enable = !(cfg_lso_sw_stop_ok &&
                         low_speed_osc_mode[SCDC_BIT_LSO_STOP]);
   assign wdt_src_fixed_lso = !cfg_lso_sw_stop_ok;

   // ====================================================================
   // dividers
   // ====================================================================
   // aclk stands for sys_clk: slower clocks are enable pulses, never gated
   // or divided clocks, which keeps the whole block in one domain
   // four counter bits cover the largest ratio of sixteen
   logic [3:0] div_cnt;  // free prescaler counter on sys_clk
   logic sys_run;

   assign periph_code = {peripheral_clock_divider[SCDC_BIT_PERIPH_DIV_HI],
                         peripheral_clock_divider[SCDC_BIT_PERIPH_DIV_LO]};
   assign cpu_l2 = cpu_log2({periph_code,
                             cpu_clock_divider[SCDC_BIT_CPU_DIV_SEL]});
   // code 11 and undefined cpu combos are prohibited; cpu clock holds at /16, peripheral at /4
   // rather than misbehave, so a bad write is visible in status
   assign prohibited = (periph_code == 2'b11) || (cpu_l2 == 5'h1F);
   assign sys_run = int_osc_enable || ext_clk_gate_open;

   // prescaler counts while the system clock is delivered
   // a shared counter keeps ticks aligned: cpu ratios never undercut the
   // peripheral ratio, so a cpu tick always lands on a peripheral tick
   // the counter holds during stop, so ticks resume in the same phase
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         div_cnt <= 4'h0;
      end else if (sys_run) begin
         div_cnt <= div_cnt + 4'h1;
      end
   end

   // one-cycle enables at /1,/2,/4 for peripheral and /1../16 for cpu
   // enables are registered, so they lag a divider write by one cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         periph_clk_en <= 1'b0;
         cpu_clk_en <= 1'b0;
         min_instr_sys_clks <= 6'd8;
      end else begin
         unique case (periph_code)
            2'b00: periph_clk_en <= sys_run;
            2'b01: periph_clk_en <= sys_run && (div_cnt[0] == 1'b0);
            2'b10: periph_clk_en <= sys_run && (div_cnt[1:0] == 2'b00);
            default: periph_clk_en <= sys_run && (div_cnt[1:0] == 2'b00);
         endcase
         if (prohibited) begin
            // slowest legal ratio; zero instruction time marks the bad setting
            cpu_clk_en <= sys_run && (div_cnt == 4'h0);
            min_instr_sys_clks <= 6'd0;
         end else begin
            // low cpu_l2 bits of the counter all zero marks a tick
            cpu_clk_en <= sys_run &&
                          ((div_cnt & 4'((5'd1 << cpu_l2) - 5'd1)) == 4'h0);
            // shortest instruction: two cpu clocks of 2^l2 sys clocks
            // six bits: two clocks at /16 make 32, which five bits would lose
            min_instr_sys_clks <= 6'(SCDC_MIN_INSTR_CPU_CLKS) << cpu_l2;
         end
      end
   end

   // status: bit0 external source, bit1 low-speed running,
   // bit2 system clock running, bit3 prohibited divider setting
   assign status_byte = {4'h0, prohibited, sys_run, lso_enable, cfg_ext_clk_sel};

endmodule : scdc_clock_control

`default_nettype wire

// ---- testbench/scdc_clock_control_props.sv ----
`timescale 1ns/1ps
`default_nettype none
// =====================================
// port checker for the clock control
// =====================================
module scdc_clock_control_props
   import scdc_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic cfg_ext_clk_sel,
   input wire logic cfg_lso_sw_stop_ok,
   input wire logic stop_mode,
   input wire logic [5:0] min_instr_sys_clks,
   input wire logic int_osc_enable,
   input wire logic ext_clk_gate_open,
   input wire logic external_clock_pin_is_port,
   input wire logic lso_enable,
   input wire logic wdt_src_fixed_lso
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // both halves of a write taken at one edge
   sequence s_wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   // low-speed oscillator just halted
   sequence s_lso_halt;
      $fell(lso_enable);
   endsequence
   a_pin_port: assert property (
      external_clock_pin_is_port == !cfg_ext_clk_sel) else $error("pin not released");
   a_int_osc: assert property (
      int_osc_enable == (!cfg_ext_clk_sel && !stop_mode)) else $error("int osc wrong");
   a_ext_gate: assert property (
      ext_clk_gate_open == (cfg_ext_clk_sel && !stop_mode)) else $error("ext gate wrong");
   a_lso_fixed: assert property (
      !cfg_lso_sw_stop_ok |-> lso_enable && wdt_src_fixed_lso) else $error("lso not fixed");
   a_lso_halt_ok: assert property (
      s_lso_halt |-> cfg_lso_sw_stop_ok) else $error("lso halted while forbidden");
   a_lso_reset: assert property (
      $rose(aresetn) |-> lso_enable) else $error("lso stopped after reset");
   a_instr_reset: assert property (
      $rose(aresetn) |-> min_instr_sys_clks == 6'h08) else $error("reset ratio wrong");
   a_write_resp: assert property (
      s_wr_taken |-> ##2 s_axi_bvalid) else $error("write not answered");
   a_bvalid_hold: assert property (
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
endmodule : scdc_clock_control_props
bind scdc_clock_control scdc_clock_control_props scdc_clock_control_props_inst (
   .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .cfg_ext_clk_sel(cfg_ext_clk_sel), .cfg_lso_sw_stop_ok(cfg_lso_sw_stop_ok),
   .stop_mode(stop_mode), .min_instr_sys_clks(min_instr_sys_clks),
   .int_osc_enable(int_osc_enable), .ext_clk_gate_open(ext_clk_gate_open),
   .external_clock_pin_is_port(external_clock_pin_is_port), .lso_enable(lso_enable),
   .wdt_src_fixed_lso(wdt_src_fixed_lso));
`default_nettype wire

// ---- testbench/scdc_clock_control_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module scdc_clock_control_tb_top
   import scdc_pkg::*;
;
   // byte address is four times the printed index
   localparam logic [17:0] A_CPU = {SCDC_IDX_CPU_CLOCK_DIVIDER, 2'b00};
   localparam logic [17:0] A_PER = {SCDC_IDX_PERIPHERAL_CLOCK_DIVIDER, 2'b00};
   localparam logic [17:0] A_LSO = {SCDC_IDX_LOW_SPEED_OSC_MODE, 2'b00};
   localparam logic [17:0] A_BAD = 18'h00010; // nothing mapped here
   localparam logic [17:0] A_STS = {SCDC_IDX_CLOCK_STATUS, 2'b00};
   logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0, ext_sel = 1'b0, stop_ok = 1'b1, stop = 1'b0;
   logic [17:0] awaddr = '0, araddr = '0;
   logic [31:0] wdata = '0;
   logic [3:0] wstrb = '0;
   logic awready, wready, bvalid, arready, rvalid, cpu_en, per_en;
   logic int_osc, ext_gate, pin_port, lso_en, wdt_fix;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic [5:0] min_instr;
   int n_mismatch = 0, comparisons = 0;
   scdc_clock_control scdc_clock_control_inst (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .cfg_ext_clk_sel(ext_sel), .cfg_lso_sw_stop_ok(stop_ok), .stop_mode(stop),
      .cpu_clk_en(cpu_en), .periph_clk_en(per_en), .min_instr_sys_clks(min_instr),
      .int_osc_enable(int_osc), .ext_clk_gate_open(ext_gate),
      .external_clock_pin_is_port(pin_port), .lso_enable(lso_en), .wdt_src_fixed_lso(wdt_fix));
   // ==========================
   // clock, checks and verdict
   // ==========================
   initial begin
      forever #5 aclk = ~aclk;
   end
   task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t: value %h expected %h", $time, got, exp);
      end
   endtask : chk_val
   task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t: response %b expected %b", $time, got, exp);
      end
   endtask : chk_resp
   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : complete_run
   // ==========================
   // axi4-lite master
   // ==========================
   // handshakes are seen at the negedge before the taking edge, where all is settled
   task automatic wr(input logic [17:0] a, input logic [31:0] d, input logic [3:0] s,
                     output logic [1:0] r);
      logic ta, tw, da, dw;
      da = 1'b0;
      dw = 1'b0;
      @(posedge aclk);
      awaddr <= a; wdata <= d; wstrb <= s; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
      while (!(da && dw)) begin
         @(negedge aclk);
         ta = awvalid && awready;
         tw = wvalid && wready;
         @(posedge aclk);
         if (ta) begin awvalid <= 1'b0; da = 1'b1; end
         if (tw) begin wvalid <= 1'b0; dw = 1'b1; end
      end
      do @(negedge aclk); while (bvalid !== 1'b1);
      r = bresp;
      @(posedge aclk);
      bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [17:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      do @(negedge aclk); while (arready !== 1'b1);
      @(posedge aclk);
      arvalid <= 1'b0;
      do @(negedge aclk); while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      @(posedge aclk);
      rready <= 1'b0;
   endtask : rd
   // pulses of both enables over 64 cycles
   task automatic count(output logic [31:0] nc, output logic [31:0] np);
      nc = '0;
      np = '0;
      repeat (64) begin
         @(negedge aclk);
         nc = nc + {31'h0, cpu_en};
         np = np + {31'h0, per_en};
      end
   endtask : count
   // ==========================
   // tests
   // ==========================
   initial begin
      logic [31:0] d, nc, np;
      logic [1:0] r;
      static logic [17:0] ta [3] = '{A_CPU, A_PER, A_LSO};
      static logic [31:0] tm [3] = '{32'h2, 32'h3, 32'h1}; // implemented bits
      static logic [1:0] tp [6] = '{2'h0, 2'h1, 2'h0, 2'h2, 2'h1, 2'h2};
      static logic tsel [6] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
      static int tcr [6] = '{1, 2, 4, 4, 8, 16}; // cpu ratio
      static int tpr [6] = '{1, 2, 1, 4, 2, 4}; // peripheral ratio
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      @(negedge aclk);
      chk_val({26'h0, min_instr}, 32'h8);
      chk_val({31'h0, lso_en}, 32'h1);
      rd(A_CPU, d, r); chk_val(d, 32'h2);
      rd(A_PER, d, r); chk_val(d, 32'h2);
      rd(A_LSO, d, r); chk_val(d, 32'h0);
      $display("reset values done");
      for (int i = 0; i < 3; i++) begin
         wr(ta[i], 32'hFFFFFFFF, 4'hF, r); chk_resp(r, 2'b00);
         rd(ta[i], d, r); chk_val(d, tm[i]);
         wr(ta[i], 32'h0, 4'h1, r); rd(ta[i], d, r); chk_val(d, 32'h0);
      end
      wr(A_LSO, 32'h1, 4'h1, r); @(negedge aclk); chk_val({31'h0, lso_en}, 32'h0);
      wr(A_LSO, 32'h0, 4'h1, r); @(negedge aclk); chk_val({31'h0, lso_en}, 32'h1);
      $display("access widths done");
      for (int i = 0; i < 6; i++) begin
         wr(A_PER, {30'h0, tp[i]}, 4'h1, r);
         wr(A_CPU, {30'h0, tsel[i], 1'b0}, 4'h1, r);
         repeat (4) @(posedge aclk);
         count(nc, np);
         chk_val(nc, 32'(64 / tcr[i]));
         chk_val(np, 32'(64 / tpr[i]));
         chk_val({26'h0, min_instr}, {26'h0, 6'(2 * tcr[i])});
      end
      wr(A_PER, 32'h3, 4'h1, r); repeat (3) @(negedge aclk);
      chk_val({26'h0, min_instr}, 32'h0);
      count(nc, np);
      chk_val(nc, 32'h4);
      chk_val(np, 32'h10);
      $display("dividers done");
      @(posedge aclk); stop_ok <= 1'b0;
      wr(A_LSO, 32'h1, 4'h1, r); chk_resp(r, 2'b00);
      rd(A_LSO, d, r); chk_val(d, 32'h0);
      chk_val({30'h0, lso_en, wdt_fix}, 32'h3);
      for (int k = 0; k < 4; k++) begin
         @(posedge aclk); ext_sel <= k[1]; stop <= k[0];
         @(negedge aclk);
         chk_val({29'h0, int_osc, ext_gate, pin_port},
                 {29'h0, !k[1] && !k[0], k[1] && !k[0], !k[1]});
      end
      // stop with external source: no ticks at all, status shows it
      count(nc, np);
      chk_val(nc, 32'h0);
      chk_val(np, 32'h0);
      rd(A_STS, d, r); chk_val(d, 32'hB);
      chk_resp(r, 2'b00);
      wr(A_STS, 32'h0, 4'h1, r); chk_resp(r, 2'b10);
      $display("sources done");
      wr(A_BAD, 32'h1, 4'hF, r); chk_resp(r, 2'b10);
      rd(A_BAD, d, r); chk_resp(r, 2'b10); chk_val(d, 32'h0);
      @(posedge aclk); aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      rd(A_CPU, d, r); chk_val(d, 32'h2);
      rd(A_PER, d, r); chk_val(d, 32'h2);
      $display("unmapped and second reset done");
      complete_run();
   end
   // hang guard, far beyond the several hundred cycles the tests need
   initial begin
      repeat (20000) @(posedge aclk);
      n_mismatch++;
      $display("Error at %0t: timeout", $time);
      complete_run();
   end
endmodule : scdc_clock_control_tb_top
`default_nettype wire
